// >>> hw/ssew_port.v
// serial port control: status, error, shutdown and wake behaviour
// assumes a synchronous register port, serial pins from another domain
`timescale 1ns/1ps
`include "ssew_defines.vh"

// How it works
// - busy rises at transfer start, stays low in controller one-wire receive
// - busy clears at transfer end, on disable, and on mode fault
// - busy is hardware only; status register writes do not change it
// - controller back-to-back transfers keep busy high throughout
// - target continuous traffic drops busy between bytes until the next trailing serial clock edge
// - target receive disable takes effect after the byte in flight
// - controller sees select low, hardware or soft, then mode fault
// - mode fault clears port enable and controller select
// - mode fault clears by status access then first control write
// - while mode fault is set, enable and controller select cannot set
// - a target never sets mode fault; an old fault stays
// - byte while rx full sets overrun, keeps old byte, drops later
// - overrun clears by data read followed by status read
// - check mismatch set when received check word differs from rx check
// - in wait the port runs on; any enabled event wakes the device
// - halt freezes the port; controller resumes after wake
// - target in halt with select sets wake flag on first sample edge
// - irq sources tx, rx, wake and shared error enable; wake exits halt
// - tx empty cleared by data write, rx full cleared by data read
module ssew_port #(
	parameter DIV = 8'd4
) (
	// clock and reset
	input  wire       sys_clk_i,
	input  wire       reset_i,
	input  wire       clk_en_i,
	// register port
	input  wire [2:0] addr_i,
	input  wire [7:0] wdata_i,
	input  wire       wr_i,
	input  wire       rd_i,
	output reg  [7:0] rdata_o,
	// low power state
	input  wire       halt_i,
	output wire       wait_wake_o,
	output wire       halt_wake_o,
	output wire       irq_o,
	// serial pins
	input  wire       sclk_i,
	input  wire       select_n_i,
	input  wire       sdi_i,
	output reg        sclk_o,
	output reg        sclk_oe_o,
	output reg        sdo_o,
	output reg        sdo_oe_o
);
	// pin synchronisers
	reg [1:0] sclk_s;
	reg [1:0] sel_s;
	reg [1:0] sdi_s;
	reg       sclk_d1;

	// control registers and data buffers
	reg [7:0] cr1_q;
	reg [7:0] cr2_q;
	reg [7:0] icr_q;
	reg [7:0] tx_buf_q;
	reg [7:0] rx_buf_q;
	reg [7:0] shift_q;
	reg [7:0] rxchk_q;
	reg [7:0] txchk_q;

	// status flags and clear sequences
	reg       txe_q;
	reg       rxf_q;
	reg       ovr_q;
	reg       mode_fault_flag_q;
	reg       chkerr_q;
	reg       wake_q;
	reg       busy_q;
	reg       ovr_lock_q;
	reg       mode_fault_flag_seen_q;
	reg       dr_rd_seen_q;
	reg       chk_phase_q;

	// transfer engine
	reg [3:0] bit_q;
	reg       active_q;
	reg       gap_q;
	reg       halt_seen_q;
	reg [7:0] div_q;

	wire en       = cr1_q[`SSEW_CR1_EN];
	wire ctrl     = cr1_q[`SSEW_CR1_CTRL];
	wire cpol     = cr1_q[`SSEW_CR1_CPOL];
	wire clock_phase_bit     = cr1_q[`SSEW_CR1_CLOCK_PHASE_BIT];
	wire onew     = cr2_q[`SSEW_CR2_ONEW];
	wire onew_out = cr2_q[`SSEW_CR2_ONEWOUT];
	wire rx_only  = cr2_q[`SSEW_CR2_RECEIVE_ONLY_BIT] | (onew & ~onew_out);
	wire sel_n    = cr2_q[`SSEW_CR2_SOFTSEL] ? cr2_q[`SSEW_CR2_SELLVL]
	                                         : sel_s[1];
	// first stage read only by second
	wire s_lvl    = sclk_s[1];
	wire s_rise   = s_lvl & ~sclk_d1;
	wire s_fall   = ~s_lvl & sclk_d1;
	wire lead     = cpol ? s_fall : s_rise;
	wire trail    = cpol ? s_rise : s_fall;
	wire t_sample = clock_phase_bit ? trail : lead;
	wire t_shift  = clock_phase_bit ? lead : trail;
	wire sr_acc   = (rd_i | wr_i) && addr_i == `SSEW_OFF_SR;
	wire dr_wr    = wr_i && addr_i == `SSEW_OFF_DR;
	wire dr_rd    = rd_i && addr_i == `SSEW_OFF_DR;
	wire sr_rd    = rd_i && addr_i == `SSEW_OFF_SR;
	wire cr1_wr   = wr_i && addr_i == `SSEW_OFF_CR1;
	wire run      = clk_en_i & ~halt_i;
	wire fault    = en & ctrl & ~sel_n;
	wire ctl_go   = ctrl & en & ~active_q & (rx_only | ~txe_q);
	// controller generates serial clock from its own divider
	wire c_tick   = active_q & ctrl & (div_q == DIV);
	// leading edge leaves the idle level; clock_phase_bit picks sample or shift
	wire c_samp   = c_tick & ~(sclk_o ^ cpol ^ clock_phase_bit);
	wire c_shft   = c_tick & (sclk_o ^ cpol ^ clock_phase_bit);
	wire samp     = ctrl ? c_samp : (t_sample & ~sel_n & active_q);
	wire byte_end = samp & (bit_q == `SSEW_BYTE_BITS - 4'h1);
	wire [7:0] rx_word = {shift_q[6:0], sdi_s[1]};

	assign irq_o = (txe_q & icr_q[`SSEW_ICR_TX_EMPTY_IRQ_ENABLE]) |
	               (rxf_q & icr_q[`SSEW_ICR_RX_FULL_IRQ_ENABLE]) |
	               (wake_q & icr_q[`SSEW_ICR_WAKE_IRQ_ENABLE]) |
	               ((mode_fault_flag_q | ovr_q | chkerr_q) &
	                icr_q[`SSEW_ICR_ERROR_IRQ_ENABLE]);
	assign wait_wake_o = irq_o;
	assign halt_wake_o = wake_q & icr_q[`SSEW_ICR_WAKE_IRQ_ENABLE];

	// pin synchronisers run even in halt so wake can be seen
	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			sclk_s  <= 2'b00;
			sel_s   <= 2'b11;
			sdi_s   <= 2'b00;
			sclk_d1 <= 1'b0;
		end else if (clk_en_i) begin
			sclk_s  <= {sclk_s[0], sclk_i};
			sel_s   <= {sel_s[0], select_n_i};
			sdi_s   <= {sdi_s[0], sdi_i};
			sclk_d1 <= sclk_s[1];
		end
	end

	// wake path runs on in halt, reading the frozen controller and select settings
	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			wake_q      <= 1'b0;
			halt_seen_q <= 1'b0;
		end else if (clk_en_i) begin
			if (!halt_i)
				halt_seen_q <= 1'b0;
			if (halt_i && !ctrl && !sel_n && t_sample && !halt_seen_q) begin
				wake_q      <= 1'b1;
				halt_seen_q <= 1'b1;
			end else if (run && wr_i && addr_i == `SSEW_OFF_SR &&
			             !wdata_i[`SSEW_SR_WAKE])
				wake_q <= 1'b0;
		end
	end

	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			// registers and buffers
			cr1_q        <= 8'h00;
			cr2_q        <= 8'h00;
			icr_q        <= 8'h00;
			tx_buf_q     <= 8'h00;
			rx_buf_q     <= 8'h00;
			shift_q      <= 8'h00;
			rxchk_q      <= 8'h00;
			txchk_q      <= 8'h00;
			// flags and clear sequences
			txe_q        <= 1'b1;
			rxf_q        <= 1'b0;
			ovr_q        <= 1'b0;
			mode_fault_flag_q       <= 1'b0;
			chkerr_q     <= 1'b0;
			busy_q       <= 1'b0;
			ovr_lock_q   <= 1'b0;
			mode_fault_flag_seen_q  <= 1'b0;
			dr_rd_seen_q <= 1'b0;
			chk_phase_q  <= 1'b0;
			// engine idle, pins released
			bit_q        <= 4'h0;
			active_q     <= 1'b0;
			gap_q        <= 1'b0;
			div_q        <= 8'h00;
			sclk_o       <= 1'b0;
			sclk_oe_o    <= 1'b0;
			sdo_o        <= 1'b0;
			sdo_oe_o     <= 1'b0;
			rdata_o      <= 8'h00;
		end else if (run) begin
			// register port writes
			if (cr1_wr) begin
				cr1_q <= wdata_i;
				if (mode_fault_flag_q) begin
					cr1_q[`SSEW_CR1_EN]   <= 1'b0;
					cr1_q[`SSEW_CR1_CTRL] <= 1'b0;
				end
			end
			if (wr_i && addr_i == `SSEW_OFF_CR2) begin
				cr2_q <= wdata_i;
				if (wdata_i[`SSEW_CR2_CHKEN] && !cr2_q[`SSEW_CR2_CHKEN]) begin
					rxchk_q <= 8'h00;
					txchk_q <= 8'h00;
				end
			end
			if (wr_i && addr_i == `SSEW_OFF_ICR)
				icr_q <= {wdata_i[7:4], 4'h0};
			if (dr_wr) begin
				tx_buf_q <= wdata_i;
				txe_q    <= 1'b0;
			end
			if (dr_rd)
				rxf_q <= 1'b0;
			rdata_o <= 8'h00;
			if (rd_i) begin
				case (addr_i)
				`SSEW_OFF_CR1:   rdata_o <= cr1_q;
				`SSEW_OFF_CR2:   rdata_o <= cr2_q;
				`SSEW_OFF_ICR:   rdata_o <= icr_q;
				`SSEW_OFF_SR:    rdata_o <= {busy_q, ovr_q, mode_fault_flag_q, chkerr_q,
				                             wake_q, 1'b0, txe_q, rxf_q};
				`SSEW_OFF_DR:    rdata_o <= rx_buf_q;
				`SSEW_OFF_RXCHK: rdata_o <= rxchk_q;
				`SSEW_OFF_TXCHK: rdata_o <= txchk_q;
				default:         rdata_o <= 8'h00;
				endcase
			end
			// status write-zero clear of the check error bit; set wins below
			if (wr_i && addr_i == `SSEW_OFF_SR && !wdata_i[`SSEW_SR_CHKERR])
				chkerr_q <= 1'b0;
			// mode fault clear sequence
			if (sr_acc && mode_fault_flag_q)
				mode_fault_flag_seen_q <= 1'b1;
			if (cr1_wr && mode_fault_flag_seen_q) begin
				mode_fault_flag_q      <= 1'b0;
				mode_fault_flag_seen_q <= 1'b0;
			end
			// overrun clear sequence
			if (dr_rd)
				dr_rd_seen_q <= 1'b1;
			if (sr_rd && dr_rd_seen_q) begin
				ovr_q        <= 1'b0;
				ovr_lock_q   <= 1'b0;
				dr_rd_seen_q <= 1'b0;
			end
			if (fault) begin
				mode_fault_flag_q <= 1'b1;
				mode_fault_flag_seen_q <= 1'b0;
				cr1_q[`SSEW_CR1_EN]   <= 1'b0;
				cr1_q[`SSEW_CR1_CTRL] <= 1'b0;
			end
			// clock output needs an enabled controller; data output also driven by a selected target
			sclk_oe_o <= en & ctrl & ~fault;
			sdo_oe_o  <= en & ~fault & ~rx_only & (ctrl | ~sel_n);
			if (!active_q)
				sclk_o <= cpol;
			// transfer engine
			if (ctrl && active_q)
				div_q <= c_tick ? 8'h00 : div_q + 8'h01;
			// shift edge only puts the next bit out; the sample edge
			// does the one shift per bit, so no bit is skipped
			if (t_shift && !ctrl && active_q && !sel_n)
				sdo_o <= shift_q[7];
			if (c_tick)
				sclk_o <= ~sclk_o;
			if (c_shft)
				sdo_o <= shift_q[7];
			if (samp) begin
				shift_q <= rx_word;
				bit_q   <= bit_q + 4'h1;
			end
			// start: load byte or check word; busy follows the mode
			if (ctl_go || (!ctrl && en && !active_q && !sel_n && !gap_q)) begin
				active_q <= 1'b1;
				shift_q  <= cr2_q[`SSEW_CR2_CHKNEXT] ? txchk_q : tx_buf_q;
				sdo_o    <= cr2_q[`SSEW_CR2_CHKNEXT] ? txchk_q[7] : tx_buf_q[7];
				chk_phase_q <= cr2_q[`SSEW_CR2_CHKNEXT];
				if (cr2_q[`SSEW_CR2_CHKNEXT])
					cr2_q[`SSEW_CR2_CHKNEXT] <= 1'b0;
				else
					txe_q <= 1'b1;
				bit_q <= 4'h0;
				div_q <= 8'h00;
				busy_q <= ~(ctrl & onew & ~onew_out);
			end
			if (gap_q && (trail || sel_n))
				gap_q <= 1'b0;
			// byte complete: capture, check, then reload or go idle
			if (byte_end) begin
				bit_q <= 4'h0;
				if (chk_phase_q && cr2_q[`SSEW_CR2_CHKEN] && rx_word != rxchk_q)
					chkerr_q <= 1'b1;
				if (!chk_phase_q && cr2_q[`SSEW_CR2_CHKEN]) begin
					rxchk_q <= rxchk_q ^ rx_word;
					txchk_q <= txchk_q ^ shift_q;
				end
				if (rxf_q || ovr_lock_q) begin
					ovr_q      <= 1'b1;
					ovr_lock_q <= 1'b1;
				end else begin
					rx_buf_q <= rx_word;
					rxf_q    <= 1'b1;
				end
				if (ctrl && en && (rx_only || !txe_q || dr_wr)) begin
					// back to back: reload without dropping busy
					shift_q <= dr_wr ? wdata_i : tx_buf_q;
					if (!rx_only)
						txe_q <= 1'b1;
					chk_phase_q <= 1'b0;
				end else begin
					active_q <= 1'b0;
					busy_q   <= 1'b0;
					gap_q    <= ~ctrl;
				end
			end
			// target deselected mid-byte: end the frame here rather
			// than hold busy until the next select
			if (!ctrl && active_q && sel_n) begin
				active_q <= 1'b0;
				busy_q   <= 1'b0;
				bit_q    <= 4'h0;
			end
			if (!en || fault) begin
				// target finishes the byte in flight before going idle
				if (ctrl || fault || !active_q) begin
					active_q <= 1'b0;
					busy_q   <= 1'b0;
				end
			end
		end
	end
endmodule

// >>> hw/ssew_defines.vh
// register offsets, field positions and reset values for the serial port
// included by the single design file; definitions only
`ifndef SSEW_DEFINES_VH
`define SSEW_DEFINES_VH
`define SSEW_OFF_CR1      3'h0
`define SSEW_OFF_CR2      3'h1
`define SSEW_OFF_ICR      3'h2
`define SSEW_OFF_SR       3'h3
`define SSEW_OFF_DR       3'h4
`define SSEW_OFF_RXCHK    3'h6
`define SSEW_OFF_TXCHK    3'h7
// first control register fields
`define SSEW_CR1_EN       6
`define SSEW_CR1_CTRL     2
`define SSEW_CR1_CPOL     1
`define SSEW_CR1_CLOCK_PHASE_BIT     0
// second control register fields
`define SSEW_CR2_ONEW     7
`define SSEW_CR2_ONEWOUT  6
`define SSEW_CR2_CHKEN    5
`define SSEW_CR2_CHKNEXT  4
`define SSEW_CR2_RECEIVE_ONLY_BIT   2
`define SSEW_CR2_SOFTSEL  1
`define SSEW_CR2_SELLVL   0
// irq control register fields
`define SSEW_ICR_TX_EMPTY_IRQ_ENABLE     7
`define SSEW_ICR_RX_FULL_IRQ_ENABLE     6
`define SSEW_ICR_ERROR_IRQ_ENABLE    5
`define SSEW_ICR_WAKE_IRQ_ENABLE     4
// status register fields
`define SSEW_SR_BUSY      7
`define SSEW_SR_OVR       6
`define SSEW_SR_MODE_FAULT_FLAG      5
`define SSEW_SR_CHKERR    4
`define SSEW_SR_WAKE      3
`define SSEW_SR_TXE       1
`define SSEW_SR_RXF       0
`define SSEW_RST_SR       8'h02
`define SSEW_BYTE_BITS    4'h8
`endif

// >>> testbench/ssew_asserts.sv
// pin-level checks on the serial port
// assumes one clock domain and a bind onto every ssew_port
`timescale 1ns/1ps
module ssew_asserts (
	// clock and reset
	input wire       sys_clk_i,
	input wire       reset_i,
	// register port and low power
	input wire       wr_i,
	input wire       rd_i,
	input wire [7:0] rdata_o,
	input wire       halt_i,
	input wire       wait_wake_o,
	input wire       halt_wake_o,
	input wire       irq_o,
	// serial pins
	input wire       select_n_i,
	input wire       sclk_o,
	input wire       sclk_oe_o,
	input wire       sdo_o,
	input wire       sdo_oe_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	// controller driving while the select pin is pulled low
	sequence ctl_sel_low;
		(sclk_oe_o && !select_n_i) [*2];
	endsequence
	chk_wait_is_irq: assert property (wait_wake_o == irq_o)
		else $error("wait wake differs from irq");
	chk_wake_in_irq: assert property (halt_wake_o |-> irq_o)
		else $error("wake request missing from irq");
	chk_read_slot: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data outside its slot");
	chk_halt_frozen: assert property (halt_i && $past(halt_i) |->
		$stable(sclk_o) && $stable(sdo_o) && $stable(sclk_oe_o))
		else $error("pins moved in halt");
	chk_fault_stops: assert property (ctl_sel_low |-> ##[1:3] !sclk_oe_o)
		else $error("outputs still driven after fault");
	chk_wake_cause: assert property ($rose(halt_wake_o) |->
		$past(halt_i) || $past(wr_i))
		else $error("wake outside halt");
	chk_irq_drop: assert property ($fell(irq_o) |->
		$past(wr_i) || $past(rd_i))
		else $error("irq dropped without access");
	chk_reset_quiet: assert property (disable iff (1'b0)
		reset_i |=> !irq_o && !sclk_oe_o && !sdo_oe_o)
		else $error("outputs active in reset");
endmodule
bind ssew_port ssew_asserts ssew_asserts_inst (
	.sys_clk_i(sys_clk_i), .reset_i(reset_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .halt_i(halt_i), .wait_wake_o(wait_wake_o),
	.halt_wake_o(halt_wake_o), .irq_o(irq_o), .select_n_i(select_n_i),
	.sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .sdo_o(sdo_o),
	.sdo_oe_o(sdo_oe_o)
);

// >>> testbench/ssew_far_end.sv
// far end of the link: echoing target, or controller on request
// assumes idle clock low, sample on rising edge, msb first
`timescale 1ns/1ps
module ssew_far_end (
	// from the port
	input  wire sclk_o,
	input  wire sclk_oe_o,
	input  wire sdo_o,
	// to the port
	output reg  sclk_i,
	output reg  select_n_i,
	output reg  sdi_i
);
	reg [7:0] got = 8'h00;
	reg [7:0] reply = 8'h3c;
	reg [2:0] cnt = 3'd0;
	initial begin
		sclk_i = 1'b0;
		select_n_i = 1'b1;
		sdi_i = 1'b0;
	end
	always @(posedge sclk_o) got <= {got[6:0], sdo_o};
	always @(posedge sclk_oe_o) begin
		cnt = 3'd0;
		sdi_i = reply[7];
	end
	// answer byte is the one heard in the frame before
	always @(negedge sclk_o) if (sclk_oe_o === 1'b1) begin
		cnt = cnt + 3'd1;
		if (cnt == 3'd0)
			reply = got;
		sdi_i = reply[3'd7 - cnt];
	end
	task pull_sel(input v);
		#3 select_n_i = v;
	endtask
	task send(input [7:0] b);
		integer i;
		begin
			#7;
			select_n_i = 1'b0;
			for (i = 7; i >= 0; i = i - 1) begin
				sdi_i = b[i];
				#80 sclk_i = 1'b1;
				#80 sclk_i = 1'b0;
			end
			#80 select_n_i = 1'b1;
			// released line shows the inverse, not a stale bit
			sdi_i = ~b[0];
		end
	endtask
endmodule

// >>> testbench/tb_top.sv
// bench for the serial port: registers, faults, overrun, halt wake
// assumes the far-end model and the bound checker
`timescale 1ns/1ps
module tb_top;
	reg        sys_clk_i = 1'b0;
	reg        reset_i = 1'b1;
	reg  [2:0] addr_i = 3'h0;
	reg  [7:0] wdata_i = 8'h00;
	reg        wr_i = 1'b0;
	reg        rd_i = 1'b0;
	reg        halt_i = 1'b0;
	wire [7:0] rdata_o;
	wire       wait_wake_o, halt_wake_o, irq_o, sclk_i, select_n_i, sdi_i;
	wire       sclk_o, sclk_oe_o, sdo_o, sdo_oe_o;
	reg  [7:0] v;
	integer    error_cnt = 0;
	integer    compares = 0;
	integer    n;
	always #10 sys_clk_i = ~sys_clk_i;
	ssew_port ssew_port_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.clk_en_i(1'b1), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .halt_i(halt_i),
		.wait_wake_o(wait_wake_o), .halt_wake_o(halt_wake_o), .irq_o(irq_o),
		.sclk_i(sclk_i), .select_n_i(select_n_i), .sdi_i(sdi_i),
		.sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .sdo_o(sdo_o),
		.sdo_oe_o(sdo_oe_o));
	ssew_far_end far_end_inst (.sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o),
		.sdo_o(sdo_o), .sclk_i(sclk_i), .select_n_i(select_n_i),
		.sdi_i(sdi_i));
	task wr(input [2:0] a, input [7:0] d);
		begin
			addr_i <= a;
			wdata_i <= d;
			wr_i <= 1'b1;
			@(posedge sys_clk_i);
			wr_i <= 1'b0;
			@(posedge sys_clk_i);
		end
	endtask
	task rd(input [2:0] a);
		begin
			addr_i <= a;
			rd_i <= 1'b1;
			@(posedge sys_clk_i);
			rd_i <= 1'b0;
			@(negedge sys_clk_i);
			v = rdata_o;
			@(posedge sys_clk_i);
		end
	endtask
	task chk(input [63:0] what, input [7:0] exp, input [7:0] m);
		begin
			compares = compares + 1;
			if ((v & m) !== exp) begin
				error_cnt = error_cnt + 1;
				$display("wrong value %0s exp %h got %h", what, exp, v & m);
			end
		end
	endtask
	task poll(input [2:0] a, input [7:0] m, input [7:0] exp);
		begin
			n = 0;
			rd(a);
			while ((v & m) !== exp && n < 300) begin
				n = n + 1;
				rd(a);
			end
			chk("poll", exp, m);
		end
	endtask
	task xfer(input [7:0] b);
		begin
			wr(3'h4, b);
			poll(3'h3, 8'h80, 8'h80);
			poll(3'h3, 8'h80, 8'h00);
		end
	endtask
	task t_reset;
		begin
			rd(3'h3);
			chk("status", 8'h02, 8'hff);
			rd(3'h5);
			chk("hole", 8'h00, 8'hff);
			wr(3'h3, 8'hff);
			rd(3'h3);
			chk("busy", 8'h00, 8'h80);
		end
	endtask
	task t_ctl;
		begin
			wr(3'h0, 8'h44);
			xfer(8'ha5);
			rd(3'h3);
			chk("status", 8'h03, 8'hff);
			xfer(8'h5a);
			wr(3'h2, 8'h20);
			@(negedge sys_clk_i);
			v = {7'h00, irq_o};
			chk("irq", 8'h01, 8'hff);
			rd(3'h3);
			chk("overrun", 8'h43, 8'hff);
			rd(3'h4);
			chk("data", 8'h3c, 8'hff);
			rd(3'h3);
			rd(3'h3);
			chk("cleared", 8'h02, 8'hff);
			wr(3'h2, 8'h00);
			wr(3'h0, 8'h00);
		end
	endtask
	task t_fault;
		begin
			wr(3'h0, 8'h44);
			far_end_inst.pull_sel(1'b0);
			poll(3'h0, 8'h44, 8'h00);
			wr(3'h0, 8'h44);
			rd(3'h0);
			chk("control", 8'h00, 8'h44);
			rd(3'h3);
			chk("fault", 8'h20, 8'h20);
			far_end_inst.pull_sel(1'b1);
			wr(3'h0, 8'h00);
			rd(3'h3);
			chk("fault", 8'h00, 8'h20);
		end
	endtask
	task t_receive_only_bit;
		begin
			wr(3'h1, 8'h04);
			wr(3'h0, 8'h44);
			rd(3'h3);
			chk("busy", 8'h80, 8'h80);
			poll(3'h3, 8'h01, 8'h01);
			rd(3'h4);
			chk("data", 8'h5a, 8'hff);
			repeat (10) @(posedge sys_clk_i);
			wr(3'h0, 8'h04);
			rd(3'h3);
			chk("stopped", 8'h02, 8'hff);
			wr(3'h1, 8'h00);
		end
	endtask
	task t_wake;
		begin
			wr(3'h0, 8'h40);
			wr(3'h2, 8'h10);
			wr(3'h4, 8'haa);
			halt_i <= 1'b1;
			far_end_inst.send(8'haa);
			v = {7'h00, halt_wake_o};
			chk("wake line", 8'h01, 8'hff);
			@(posedge sys_clk_i);
			halt_i <= 1'b0;
			@(posedge sys_clk_i);
			rd(3'h3);
			chk("wake", 8'h08, 8'h28);
			wr(3'h3, 8'hf7);
			rd(3'h3);
			chk("wake", 8'h00, 8'h08);
		end
	endtask
	task give_verdict;
		begin
			$display("errors %0d compares %0d", error_cnt, compares);
			if (error_cnt == 0 && compares > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	initial begin
		repeat (6) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		t_reset;
		t_ctl;
		t_fault;
		t_receive_only_bit;
		t_wake;
		give_verdict;
	end
	initial begin
		#400000;
		error_cnt = error_cnt + 1;
		give_verdict;
	end
endmodule
